//--- verilog/pli_pkg.sv
// constants, codes and carrier types for the phy-link interface block
//
// Functional notes
// - 100 rate uses two data lines, 200 four
// - unused data lines driven low by owner
// - phy starts everything except link requests
// - phy codes: idle 11, status 01, receive 10
// - request bits sent first-bit-first, one per clock
// - stream lengths 7, 9 and 17 bits
// - receive code discards fair or priority request
// - iso request held until other type/done
// - immediate request granted at packet end
// - bad crc: link held off 160 ns
// - read request answered by retried status
// - write request stored when stream completes
// - status only from idle, 01 with bits
// - aborted status retried until delivered
// - one idle cycle between status transfers
// - four flag bits, sixteen when needed
// - node address register sent after self-id
// - status layout: flags, address, data
// - request type codes, 110/111 reserved
package pli_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;     // pclk period
  localparam int HOLDOFF_NS    = 160;   // link hold-off after packet
  // least time, so round up
  localparam int HOLDOFF_CYC   =
    (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] LINK_GUARD = 2'h3; // sync settle cycles

  // ----------------------------------------------------------------
  // control pair codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CTL_IDLE  = 2'h3; // phy idle / link release
  localparam logic [1:0] CTL_STAT  = 2'h1; // phy status / link hold
  localparam logic [1:0] CTL_RECV  = 2'h2; // phy receive / link send
  localparam logic [1:0] CTL_GRANT = 2'h0; // phy transmit grant

  // ----------------------------------------------------------------
  // request types and stream lengths
  // ----------------------------------------------------------------
  localparam logic [2:0] RQ_IMM  = 3'h0;
  localparam logic [2:0] RQ_ISO  = 3'h1;
  localparam logic [2:0] RQ_PRI  = 3'h2;
  localparam logic [2:0] RQ_FAIR = 3'h3;
  localparam logic [2:0] RQ_READ = 3'h4;
  localparam logic [2:0] RQ_WRIT = 3'h5;
  localparam logic [4:0] LEN_BUS  = 5'h07;
  localparam logic [4:0] LEN_READ = 5'h09;
  localparam logic [4:0] LEN_WRIT = 5'h11;
  localparam logic [4:0] TYPE_CNT = 5'h04; // type bits all in

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int ST_FLAG_LSB = 0;  // 4 flag bits
  localparam int ST_ADDR_LSB = 4;  // 4 address bits
  localparam int ST_DATA_LSB = 8;  // 8 data bits
  localparam logic [2:0] PAIRS_SHORT = 3'h1; // 4 bits, less one
  localparam logic [2:0] PAIRS_FULL  = 3'h7; // 16 bits, less one

  // ----------------------------------------------------------------
  // apb register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00; // control
  localparam logic [7:0] OFS_STAT = 8'h04; // state, read only
  localparam logic [7:0] OFS_LAST = 8'h08; // last request
  localparam int CTRL_RATE_BIT = 0;        // link data at 200
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // carrier and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ctl;   // control pair
    logic [3:0] data;  // data lines, bit 0 is line 0
  } pli_link_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_STAT = 7'h02, ST_RECV = 7'h04,
    ST_GRNT = 7'h08, ST_GIDL = 7'h10, ST_LINK = 7'h20,
    ST_HOLD = 7'h40
  } pli_state_type;

endpackage

//--- verilog/pli_phy_link.sv
// phy side of the phy-link interface with apb control registers
`timescale 1ns/100ps
module pli_phy_link
  import pli_pkg::*;
#(
  parameter logic [3:0] PHYID_ADDR = 4'h0  // node address register
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [7:0]   paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         link_request_line,
  input  wire pli_link_type link_in,
  output pli_link_type      link_out,
  output logic              link_oe,
  input  wire logic         cable_power_state,
  input  wire logic         arb_reset_gap,
  input  wire logic         subaction_gap,
  input  wire logic         bus_reset,
  input  wire logic         state_timeout,
  input  wire logic         self_id_done,
  input  wire logic         rx_active,
  input  wire logic [3:0]   rx_data,
  input  wire logic         rx_rate_200,
  input  wire logic         arb_won,
  input  wire logic         iso_done,
  output logic              arb_request,
  output logic              tx_active,
  output logic [3:0]        tx_data
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // keep only the lines used at the rate, rest low
  function automatic logic [3:0] rate_mask(input logic [3:0] d,
                                           input logic       r200);
    rate_mask = r200 ? d : {2'h0, d[1:0]};
  endfunction

  // stream length from request type
  function automatic logic [4:0] req_len(input logic [2:0] t);
    case (t)
      RQ_READ: req_len = LEN_READ;
      RQ_WRIT: req_len = LEN_WRIT;
      default: req_len = LEN_BUS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pli_state_type state;            // interface owner state
  pli_link_type  lin_s1;           // pin sync stage one
  pli_link_type  lin_s2;           // pin sync stage two
  logic          link_request_line_s1;          // request line sync one
  logic          link_request_line_s2;          // request line sync two
  logic          cps_s1;           // cable power sync one
  logic          cps_s2;           // cable power sync two
  logic          cps_s3;           // cable power, for edge
  logic          idle_once;        // idle held a full cycle
  logic [7:0]    hold_cnt;         // hold-off countdown
  logic [1:0]    guard;            // ignore stale sync values
  logic          rq_busy;          // stream in progress
  logic [4:0]    rq_cnt;           // bit index in stream
  logic [15:0]   rq_sh;            // shifted stream bits
  logic [2:0]    rq_type;          // latched request type
  logic          rq_lost;          // receive seen mid-stream
  logic          rq_done;          // stop bit sampled
  logic [3:0]    rq_addr;          // register address field
  logic [7:0]    rq_data;          // register data field
  logic [7:0]    rq_count;         // requests seen, wraps
  logic          imm_pend;         // immediate request held
  logic          iso_pend;         // isochronous request held
  logic          pri_pend;         // priority request held
  logic          fair_pend;        // fair request held
  logic [3:0]    flag_pend;        // sticky status flags
  logic [3:0]    flag_set;         // flag events this cycle
  logic          full_pend;        // full status owed
  logic [3:0]    full_addr;        // register to send
  logic [7:0]    regs [16];        // phy register array
  logic [15:0]   stat_word;        // word to start sending
  logic [13:0]   st_sh;            // remaining status bits
  logic [2:0]    st_cnt;           // pairs left after this
  logic          st_full;          // sending sixteen bits
  logic [3:0]    st_sent;          // flags in this transfer
  logic          start_rx;         // idle to receive
  logic          grant_go;         // idle to grant
  logic          stat_go;          // idle to status
  logic          stat_done;        // status fully delivered
  logic          rx_end;           // receive finishing
  logic [31:0]   ctrl;             // control register
  logic [31:0]   rd_mux;           // read data select
  logic          rd_hit;           // address is mapped

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // pins are driven by the link on its own timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_s1  <= '0;
      lin_s2  <= '0;
      link_request_line_s1 <= 1'b0;
      link_request_line_s2 <= 1'b0;
      cps_s1  <= 1'b1;
      cps_s2  <= 1'b1;
      cps_s3  <= 1'b1;
    end else begin
      lin_s1  <= link_in;
      lin_s2  <= lin_s1;
      link_request_line_s1 <= link_request_line;
      link_request_line_s2 <= link_request_line_s1;
      cps_s1  <= cable_power_state;
      cps_s2  <= cps_s1;
      cps_s3  <= cps_s2;
    end
  end

  // ----------------------------------------------------------------
  // decisions taken from idle
  // ----------------------------------------------------------------
  // receive beats a grant, a grant beats status
  assign start_rx  = (state == ST_IDLE) && rx_active;
  assign grant_go  = (state == ST_IDLE) && !rx_active && arb_won &&
                     arb_request;
  // status needs a prior idle cycle on the pins
  assign stat_go   = (state == ST_IDLE) && !rx_active && !grant_go &&
                     idle_once && (full_pend || (|flag_pend));
  assign stat_done = (state == ST_STAT) && !rx_active &&
                     (st_cnt == 3'h0);
  assign rx_end    = (state == ST_RECV) && !rx_active;
  assign stat_word = {full_pend ? regs[full_addr] : 8'h00,
                      full_pend ? full_addr : 4'h0, flag_pend};
  assign flag_set  = {state_timeout || (cps_s3 && !cps_s2),
                      bus_reset, subaction_gap, arb_reset_gap};

  // ----------------------------------------------------------------
  // interface state machine and pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      link_out <= '{ctl: CTL_IDLE, data: 4'h0};
      link_oe  <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          link_oe <= 1'b1;
          if (start_rx) begin
            state    <= ST_RECV;
            link_out <= '{ctl: CTL_RECV,
                           data: rate_mask(rx_data, rx_rate_200)};
          end else if (grant_go) begin
            state    <= ST_GRNT;
            link_out <= '{ctl: CTL_GRANT, data: 4'h0};
          end else if (stat_go) begin
            state    <= ST_STAT;
            link_out <= '{ctl: CTL_STAT,
                           data: {2'h0, stat_word[1:0]}};
          end else begin
            link_out <= '{ctl: CTL_IDLE, data: 4'h0};
          end
        end
        ST_STAT: begin
          if (rx_active) begin
            // abort; pending status stays and is retried
            state    <= ST_RECV;
            link_out <= '{ctl: CTL_RECV,
                           data: rate_mask(rx_data, rx_rate_200)};
          end else if (st_cnt != 3'h0) begin
            link_out <= '{ctl: CTL_STAT,
                           data: {2'h0, st_sh[1:0]}};
          end else begin
            state    <= ST_IDLE;
            link_out <= '{ctl: CTL_IDLE, data: 4'h0};
          end
        end
        ST_RECV: begin
          if (rx_active) begin
            link_out <= '{ctl: CTL_RECV,
                           data: rate_mask(rx_data, rx_rate_200)};
          end else if (imm_pend) begin
            // no arbitration for an acknowledgment
            state    <= ST_GRNT;
            link_out <= '{ctl: CTL_GRANT, data: 4'h0};
          end else begin
            state    <= ST_IDLE;
            link_out <= '{ctl: CTL_IDLE, data: 4'h0};
          end
        end
        ST_GRNT: begin
          state    <= ST_GIDL;          // grant, then one idle
          link_out <= '{ctl: CTL_IDLE, data: 4'h0};
        end
        ST_GIDL: begin
          state   <= ST_LINK;
          link_oe <= 1'b0;
        end
        ST_LINK: begin
          // sync stages still hold our own idle for a while
          if (guard == 2'h0 && lin_s2.ctl == CTL_IDLE) begin
            if (hold_cnt != 8'h00) begin
              state <= ST_HOLD;
            end else begin
              state   <= ST_IDLE;
              link_oe <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (hold_cnt == 8'h00) begin
            state   <= ST_IDLE;
            link_oe <= 1'b1;
          end
        end
        default: begin
          state    <= ST_IDLE;
          link_out <= '{ctl: CTL_IDLE, data: 4'h0};
          link_oe  <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // idle history, guard and hold-off timers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_once <= 1'b0;
      guard     <= LINK_GUARD;
      hold_cnt  <= 8'h00;
    end else begin
      idle_once <= (state == ST_IDLE);
      guard     <= (state == ST_LINK && guard != 2'h0) ?
                   guard - 2'h1 : (state == ST_LINK ? 2'h0 : LINK_GUARD);
      if (rx_end && imm_pend) begin
        hold_cnt <= 8'(HOLDOFF_CYC);
      end else if (hold_cnt != 8'h00) begin
        hold_cnt <= hold_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // status shifter
  // ----------------------------------------------------------------
  // two bits per cycle, flags first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_sh   <= 14'h0000;
      st_cnt  <= 3'h0;
      st_full <= 1'b0;
      st_sent <= 4'h0;
    end else if (stat_go) begin
      st_sh   <= stat_word[15:2];
      st_cnt  <= full_pend ? PAIRS_FULL : PAIRS_SHORT;
      st_full <= full_pend;
      st_sent <= flag_pend;
    end else if (state == ST_STAT && st_cnt != 3'h0) begin
      st_sh   <= {2'h0, st_sh[13:2]};
      st_cnt  <= st_cnt - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // pending status flags and full status
  // ----------------------------------------------------------------
  // a new event beats the clear of a delivered flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_pend <= 4'h0;
      full_pend <= 1'b0;
      full_addr <= 4'h0;
    end else begin
      flag_pend <= (stat_done ? flag_pend & ~st_sent : flag_pend) |
                   flag_set;
      if (stat_done && st_full) begin
        full_pend <= 1'b0;
      end
      if (self_id_done) begin
        full_pend <= 1'b1;
        full_addr <= PHYID_ADDR;
      end else if (rq_done && rq_type == RQ_READ) begin
        full_pend <= 1'b1;
        full_addr <= rq_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // request stream receiver
  // ----------------------------------------------------------------
  // stop bit index is length less one
  assign rq_done = rq_busy && rq_cnt >= TYPE_CNT &&
                   rq_cnt == req_len(rq_type) - 5'h01;
  assign rq_addr = (rq_type == RQ_WRIT) ? rq_sh[11:8] : rq_sh[3:0];
  assign rq_data = rq_sh[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_busy  <= 1'b0;
      rq_cnt   <= 5'h00;
      rq_sh    <= 16'h0000;
      rq_type  <= RQ_IMM;
      rq_lost  <= 1'b0;
      rq_count <= 8'h00;
    end else if (!rq_busy) begin
      if (link_request_line_s2) begin
        rq_busy <= 1'b1;
        rq_cnt  <= 5'h01;
        rq_sh   <= 16'h0000;
        rq_lost <= (state == ST_RECV);
      end
    end else begin
      if (rq_done) begin
        rq_busy  <= 1'b0;               // stop bit taken
        rq_count <= rq_count + 8'h01;
      end else begin
        rq_sh  <= {rq_sh[14:0], link_request_line_s2};
        rq_cnt <= rq_cnt + 5'h01;
      end
      if (rq_cnt == TYPE_CNT) begin
        rq_type <= rq_sh[2:0];
      end
      if (state == ST_RECV) begin
        rq_lost <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // held bus requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm_pend  <= 1'b0;
      iso_pend  <= 1'b0;
      pri_pend  <= 1'b0;
      fair_pend <= 1'b0;
    end else begin
      // consumed by the grant at packet end
      if (rx_end) begin
        imm_pend <= 1'b0;
      end
      if (rq_done && rq_type == RQ_IMM) begin
        imm_pend <= 1'b1;
      end
      if (iso_done || (rq_done && rq_type != RQ_ISO)) begin
        iso_pend <= 1'b0;
      end else if (rq_done) begin
        iso_pend <= 1'b1;
      end
      // receive code discards fair and priority requests
      if (state == ST_RECV || grant_go) begin
        pri_pend  <= 1'b0;
        fair_pend <= 1'b0;
      end else if (rq_done && !rq_lost) begin
        pri_pend  <= pri_pend || rq_type == RQ_PRI;
        fair_pend <= fair_pend || rq_type == RQ_FAIR;
      end
      // reserved codes only clear a held iso request
    end
  end

  // registered, so the arbiter sees it a cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_request <= 1'b0;
    end else begin
      arb_request <= (iso_pend || pri_pend || fair_pend) && !grant_go;
    end
  end

  // ----------------------------------------------------------------
  // phy register array
  // ----------------------------------------------------------------
  // no reset on the array; contents are undefined until written
  always_ff @(posedge pclk) begin
    if (rq_done && rq_type == RQ_WRIT) begin
      regs[rq_addr] <= rq_data;
    end
  end

  // ----------------------------------------------------------------
  // outgoing link data toward the cable side
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active <= 1'b0;
      tx_data   <= 4'h0;
    end else begin
      tx_active <= (state == ST_LINK) && (guard == 2'h0) &&
                   (lin_s2.ctl == CTL_RECV);
      tx_data   <= rate_mask(lin_s2.data, ctrl[CTRL_RATE_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      OFS_CTRL: rd_mux = ctrl;
      OFS_STAT: rd_mux = {15'h0000, full_pend, flag_pend,
                          imm_pend, iso_pend, pri_pend, fair_pend,
                          rq_busy, state};
      OFS_LAST: rd_mux = {8'h00, rq_count, rq_sh[7:0],
                          rq_addr, 1'b0, rq_type};
      default:  rd_hit = 1'b0;
    endcase
  end

  // zero wait: ready rises in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // writes land at the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (psel && penable && pready && pwrite &&
                 paddr == OFS_CTRL) begin
      ctrl <= {31'h00000000, pwdata[CTRL_RATE_BIT]};
    end
  end

endmodule

//--- bench/pli_checker.sv
// assertion checker for the phy-link interface block
`timescale 1ns/100ps
module pli_checker
  import pli_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         rx_active,
  input wire logic         rx_rate_200,
  input wire pli_link_type link_out,
  input wire logic         link_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] run;  // cycles in the current status burst
  wire stat = link_oe && link_out.ctl == CTL_STAT;
  // burst length counter, cleared whenever status stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run <= 4'h0;
    else run <= stat ? run + 4'h1 : 4'h0;
  end
  a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_status_start: assert property (stat && !$past(stat) |->
    $past(link_out.ctl) == CTL_IDLE && $past(link_oe))
    else $error("status started from a busy bus");
  a_status_len: assert property (!stat && run != 4'h0 &&
    link_out.ctl != CTL_RECV |-> run == 4'h2 || run == 4'h8)
    else $error("status burst of wrong length");
  a_abort_recv: assert property (stat && rx_active |=>
    link_out.ctl == CTL_RECV) else $error("status not cut by receive");
  a_recv_mask: assert property (link_oe && link_out.ctl == CTL_RECV &&
    !$past(rx_rate_200) |-> link_out.data[3:2] == 2'h0)
    else $error("upper lines driven at low rate");
  a_status_low: assert property (stat |-> link_out.data[3:2] == 2'h0)
    else $error("upper lines driven in status");
  a_grant_seq: assert property (link_oe && link_out.ctl == CTL_GRANT
    |=> link_oe && link_out.ctl == CTL_IDLE ##1 !link_oe)
    else $error("grant not followed by idle then release");
  c_grant: cover property (link_oe && link_out.ctl == CTL_GRANT);
  c_full: cover property (run == 4'h8);
  c_abort: cover property (stat && rx_active);
endmodule
bind pli_phy_link pli_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .rx_active(rx_active), .rx_rate_200(rx_rate_200),
  .link_out(link_out), .link_oe(link_oe));

//--- bench/pli_link_model.sv
// behavioural link controller: request stream and granted bus
`timescale 1ns/100ps
module pli_link_model
  import pli_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         go,
  input  wire logic [16:0]  frame,
  input  wire logic         link_oe,
  input  wire pli_link_type link_out,
  output logic              link_request_line,
  output pli_link_type      link_in
);
  logic [16:0] sh;   // stream, next bit at the top
  logic [4:0]  cnt;  // bits still to shift
  logic [2:0]  own;  // cycles since the phy released the bus
  // shifter; trailing zeros keep the line low after the stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= '0;
      cnt <= 5'h00;
    end else if (go) begin
      sh <= frame;
      cnt <= 5'h11;
    end else if (cnt != 5'h00) begin
      sh <= sh << 1;
      cnt <= cnt - 5'h01;
    end
  end
  assign link_request_line = (cnt != 5'h00) && sh[16];
  // hold two cycles, send two words, then release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || link_oe) own <= 3'h0;
    else if (own != 3'h7) own <= own + 3'h1;
  end
  // wire level seen by the phy: its own drive while enabled
  assign link_in = link_oe ? link_out :
    (own < 3'h2) ? {CTL_STAT, 4'h0} :
    (own < 3'h4) ? {CTL_RECV, 4'hF} : {CTL_IDLE, 4'h0};
endmodule

//--- bench/testbench.sv
// self-checking bench for the phy-link interface block
`timescale 1ns/100ps
module testbench import pli_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, link_request_line, link_oe, arb_request, e;
  logic cable_power_state = 1, arb_reset_gap = 0, subaction_gap = 0;
  logic bus_reset = 0, state_timeout = 0, self_id_done = 0, go = 0;
  logic rx_active = 0, rx_rate_200 = 0, arb_won = 0, iso_done = 0;
  logic tx_active;
  logic [3:0] rx_data = '0, tx_data;
  logic [16:0] frame = '0;
  logic [15:0] w;
  pli_link_type link_in, link_out;
  int mismatches, checked, cyc, n;
  pli_phy_link i_dut (.*);
  pli_link_model i_link (.*);
  initial forever #4 pclk = ~pclk;
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // apb transfer: one free edge first, so psel is never set twice
  // in one step; hold request until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task send(input logic [16:0] f, input int n);
    go <= 1; frame <= f;
    @(posedge pclk);
    go <= 0;
    repeat (n) @(posedge pclk);
  endtask
  // collect n status pairs, line 0 holds the even bit
  task get_stat(input int n);
    w = '0;
    while (!(link_oe === 1'b1 && link_out.ctl === CTL_STAT)) @(negedge pclk);
    for (int i = 0; i < n; i++) begin
      w[2*i+:2] = link_out.data[1:0];
      @(negedge pclk);
    end
    @(posedge pclk);
  endtask
  task t_regs;
    apb(1, OFS_CTRL, 32'h1);
    apb(0, OFS_CTRL, 32'h0); chk(r, 32'h1);
    apb(0, 8'h0C, 32'h0); chk({r[30:0], e}, 32'h1);
  endtask
  task t_flags;
    bus_reset <= 1;
    @(posedge pclk);
    bus_reset <= 0;
    get_stat(2); chk(w, 32'h4);
    subaction_gap <= 1;
    @(posedge pclk);
    subaction_gap <= 0;
    @(posedge pclk);
    rx_active <= 1;
    repeat (2) @(posedge pclk);
    rx_active <= 0;
    get_stat(2); chk(w, 32'h2);
  endtask
  task t_regrw;
    send({1'b1, RQ_WRIT, 4'h5, 8'hA5, 1'b0}, 17);
    send({1'b1, RQ_READ, 4'h5, 1'b0, 8'h0}, 9);
    get_stat(8); chk(w, 32'hA550);
    send({1'b1, RQ_WRIT, 4'h0, 8'h3C, 1'b0}, 19);
    self_id_done <= 1;
    @(posedge pclk);
    self_id_done <= 0;
    get_stat(8); chk(w, 32'h3C00);
  endtask
  task t_grant;
    send({1'b1, RQ_ISO, 3'h0, 10'h0}, 11);
    chk(arb_request, 1);
    iso_done <= 1;
    @(posedge pclk);
    iso_done <= 0;
    repeat (2) @(posedge pclk);
    chk(arb_request, 0);
    send({1'b1, RQ_FAIR, 3'h0, 10'h0}, 11);
    chk(arb_request, 1);
    arb_won <= 1;
    @(posedge pclk);
    arb_won <= 0;
    repeat (2) @(posedge pclk);
    @(negedge pclk); chk(link_oe, 0);
    w = '0;
    while (link_oe !== 1'b1) begin
      if (tx_active === 1'b1) w = tx_data;
      @(negedge pclk);
    end
    chk(w, 32'hF);
    chk(arb_request, 0);
    @(posedge pclk);
  endtask
  // acknowledgment grant at packet end, then the hold-off
  task t_imm;
    rx_active <= 1;
    send({1'b1, RQ_IMM, 3'h0, 10'h0}, 10);
    rx_active <= 0;
    @(posedge pclk);
    @(negedge pclk); chk(link_out.ctl, CTL_GRANT);
    repeat (2) @(negedge pclk);
    n = 0;
    while (link_oe !== 1'b1) begin
      n++;
      @(negedge pclk);
    end
    chk(n + 2 >= HOLDOFF_CYC, 1);
    @(posedge pclk);
  endtask
  task t_recv;
    rx_data <= 4'hF; rx_active <= 1;
    send({1'b1, RQ_PRI, 3'h0, 10'h0}, 3);
    @(negedge pclk); chk(link_out, {CTL_RECV, 4'h3});
    @(posedge pclk);
    rx_active <= 0;
    repeat (8) @(posedge pclk);
    chk(arb_request, 0);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    chk(link_out.ctl, CTL_IDLE);
    t_regs; t_flags; t_regrw; t_grant; t_imm; t_recv;
    tally_and_finish;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish;
    end
  end
endmodule
